// ===== rtl/tfm_pkg.sv
// constants shared by the thermal fault and integrity monitor
// assumes a 40 MHz hclk and a 32-bit AHB-Lite register bus
package tfm_pkg;
  // ****************************************
  // register word offsets
  // ****************************************
  localparam logic [4:0] OFF_MAIN_SETUP  = 5'h00;
  localparam logic [4:0] OFF_EVT_ENABLE0 = 5'h04;
  localparam logic [4:0] OFF_WETTING     = 5'h08;
  localparam logic [4:0] OFF_INPUT_MODE  = 5'h0C;
  localparam logic [4:0] OFF_CHECKSUM    = 5'h10;
  localparam logic [4:0] OFF_MISC_STATUS = 5'h14;
  localparam logic [4:0] OFF_EVT_STATUS  = 5'h18;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int MS_GO        = 0;
  localparam int MS_BLK_SRC   = 1;
  localparam int MS_BLK_SNK   = 2;
  localparam int EN_CHK_IRQ   = 4;
  localparam int EV_SWITCH    = 0;
  localparam int EV_WARN      = 1;
  localparam int EV_SHUTDOWN  = 2;
  localparam int EV_PARITY    = 3;
  localparam int EV_CHK_DONE  = 4;
  localparam int NUM_EVT      = 5;
  localparam logic [31:0] RST_EVT_ENABLE0 = 32'h0000_0010;
  localparam logic [23:0] RST_WETTING     = 24'h00_0000;
  localparam logic [7:0]  RST_INPUT_MODE  = 8'h00;
  // ****************************************
  // wetting current codes
  // ****************************************
  localparam logic [2:0] WC_2MA  = 3'h2;
  localparam logic [2:0] WC_10MA = 3'h4;
  localparam logic [2:0] WC_15MA = 3'h5;
  // ****************************************
  // checksum and serial frame
  // ****************************************
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_XOR  = 16'h0000;
  localparam int          CFG_BITS = 128;
  localparam int          FRAME_W  = 32;
endpackage

// ===== rtl/tfm_crc_if.sv
// handshake between the monitor core and its checksum engine
// assumes both ends run on hclk
interface tfm_crc_if #(parameter int IW = 7);
  logic          start;
  logic          bit_in;
  logic [IW-1:0] bit_idx;
  logic          done;
  logic [15:0]   result;
  modport eng (input start, input bit_in, output bit_idx, output done, output result);
  modport ctl (output start, output bit_in, input bit_idx, input done, input result);
endinterface

// ===== rtl/tfm_crc.sv
// serial crc-16 engine, one configuration bit per clock
// assumes the caller holds the configuration still while it runs
module tfm_crc #(
  parameter int NBITS = tfm_pkg::CFG_BITS,
  parameter int IW    = 7
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control side
  tfm_crc_if.eng   crc
);
  typedef enum logic {TFM_IDLE, TFM_RUN} tfm_crc_st_t;
  tfm_crc_st_t   st_q;
  logic [15:0]   sr_q;
  logic [IW-1:0] idx_q;
  logic          done_q;
  logic [15:0]   res_q;
  wire           fb   = sr_q[15] ^ crc.bit_in;
  wire  [15:0]   sr_d = {sr_q[14:0], 1'b0} ^ (fb ? tfm_pkg::CRC_POLY : 16'h0000);
  wire           last = (idx_q == IW'(NBITS - 1));

  assign crc.bit_idx = idx_q;
  assign crc.done    = done_q;
  assign crc.result  = res_q;

  // msb first shift, seeded, no reflection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q   <= TFM_IDLE;
      sr_q   <= 16'hFFFF;
      idx_q  <= '0;
      done_q <= 1'b0;
      res_q  <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (st_q)
        TFM_IDLE:
        begin
          if (crc.start)
          begin
            sr_q  <= tfm_pkg::CRC_SEED; // R19
            idx_q <= '0;
            st_q  <= TFM_RUN;
          end
        end
        TFM_RUN:
        begin
          sr_q  <= sr_d; // R24
          idx_q <= idx_q + IW'(1);
          if (last)
          begin
            res_q  <= sr_d ^ tfm_pkg::CRC_XOR; // R19
            done_q <= 1'b1;
            st_q   <= TFM_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ===== rtl/tfm_top.sv
// thermal fault handling, serial parity check and config checksum
// assumes an AHB-Lite master, a serial host on sampled pins, and
// level comparator outputs from the analog temperature sensor
// Behaviour
// [R1] warning: alert low, event bit, thermal flag
// [R2] warning live bit held while condition lasts
// [R3] warning derates 10/15 mA settings to 2 mA
// [R4] derating held above warning minus hysteresis
// [R5] read event register clears it at deselect
// [R6] no repeat interrupt while condition persists
// [R7] derate block bits skip derating, keep interrupt
// [R8] cooling below warning: event, live clear, restore
// [R9] shutdown opens all source and sink switches
// [R10] shutdown: alert, event, flags, live bits
// [R11] serial link and registers survive shutdown
// [R12] shutdown held above shutdown minus hysteresis
// [R13] leaving shutdown: alert, event, live updates
// [R14] after shutdown derate if still warm
// [R15] after shutdown restart polling, report first cycle
// [R16] outgoing frames carry odd parity
// [R17] even parity frame discarded, alert, error event
// [R18] parity failure shown in serial status flags
// [R19] crc-16 poly 1021, seed FFFF, no reflection
// [R20] checksum covers config registers, reserved zero
// [R21] checksum go starts; result, event, interrupt
// [R22] checksum go reads one while running
// [R23] completion interrupt gated by enable bit
// [R24] msb first, ascending order, one bit/clock
//
// Decided for this implementation: the AHB-Lite register port and the address map.
module tfm_top #(
  parameter int NCH = 8
) (
  // bus clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // serial link from the host
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  output logic             alert_n,
  // temperature comparators
  input  wire logic        warn_above,
  input  wire logic        warn_hold,
  input  wire logic        sd_above,
  input  wire logic        sd_hold,
  // polling sequencer
  input  wire logic        poll_cycle_done,
  output logic             poll_restart,
  output logic [3*NCH-1:0] wc_level,
  output logic             wc_switch_on,
  output logic [NCH-1:0]   input_mode
);
  typedef enum logic [1:0] {TFM_NORMAL, TFM_WARN, TFM_SHUTDOWN} tfm_therm_t;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [6:0] sy1_q;
  logic [6:0] sy2_q;
  logic [1:0] sy3_q;
  // the 200 ns serial clock is slow enough to find edges at 40 MHz
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sy1_q <= 7'h50;
      sy2_q <= 7'h50;
      sy3_q <= 2'h2;
    end
    else
    begin
      sy1_q <= {cs_n, sclk, si, warn_above, warn_hold, sd_above, sd_hold};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q[6:5];
    end
  end
  wire cs_s    = sy2_q[6];
  wire sclk_s  = sy2_q[5];
  wire si_s    = sy2_q[4];
  wire w_above = sy2_q[3];
  wire w_hold  = sy2_q[2];
  wire s_above = sy2_q[1];
  wire s_hold  = sy2_q[0];
  wire cs_fall = sy3_q[1] & ~cs_s;
  wire cs_rise = ~sy3_q[1] & cs_s;
  wire sck_up  = ~sy3_q[0] & sclk_s & ~cs_s;
  wire sck_dn  = sy3_q[0] & ~sclk_s & ~cs_s;

  // ****************************************
  // registers
  // ****************************************
  logic                go_q;
  logic                blk_src_q;
  logic                blk_snk_q;
  logic [31:0]         en0_q;
  logic [3*NCH-1:0]    wc_cfg_q;
  logic [NCH-1:0]      mode_q;
  localparam int NUM_EVT = tfm_pkg::NUM_EVT;
  logic [15:0]         chk_q;
  logic [NUM_EVT-1:0]  evt_q;
  tfm_therm_t          st_q;
  wire warn_live = (st_q != TFM_NORMAL);
  wire sd_live   = (st_q == TFM_SHUTDOWN);

  // shared read decode for the bus and the serial link
  function automatic logic [31:0] reg_read(input logic [2:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      3'h0: v = {29'h0, blk_snk_q, blk_src_q, go_q}; // R22
      3'h1: v = en0_q;
      3'h2: v = 32'(wc_cfg_q);
      3'h3: v = 32'(mode_q);
      3'h4: v = {16'h0000, chk_q};
      3'h5: v = {30'h0, sd_live, warn_live}; // R2
      3'h6: v = 32'(evt_q);
      3'h7: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ****************************************
  // ahb-lite slave, one wait state per access
  // ****************************************
  logic       dp_q;
  logic       dp_wr_q;
  logic [2:0] dp_idx_q;
  logic       dp_map_q;
  logic       hready_q;
  logic [31:0] hrdata_q;
  wire accept  = hsel & htrans[1] & hready;
  wire wr_now  = dp_q & dp_wr_q & dp_map_q;
  wire wr_main = wr_now & (dp_idx_q == tfm_pkg::OFF_MAIN_SETUP[4:2]);
  wire wr_en0  = wr_now & (dp_idx_q == tfm_pkg::OFF_EVT_ENABLE0[4:2]);
  wire wr_wc   = wr_now & (dp_idx_q == tfm_pkg::OFF_WETTING[4:2]);
  wire wr_mode = wr_now & (dp_idx_q == tfm_pkg::OFF_INPUT_MODE[4:2]);
  wire go_start = wr_main & hwdata[tfm_pkg::MS_GO] & ~go_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_q     <= 1'b0;
      dp_wr_q  <= 1'b0;
      dp_idx_q <= 3'h0;
      dp_map_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      dp_q     <= accept;
      hready_q <= ~accept;
      if (accept)
      begin
        dp_wr_q  <= hwrite;
        dp_idx_q <= haddr[4:2];
        dp_map_q <= (haddr[31:5] == 27'h0) & (haddr[4:2] != 3'h7);
      end
      if (dp_q && !dp_wr_q)
        hrdata_q <= dp_map_q ? reg_read(dp_idx_q) : 32'h0000_0000;
    end
  end

  // config storage; reserved bits never stored so they read zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blk_src_q <= 1'b0;
      blk_snk_q <= 1'b0;
      en0_q     <= tfm_pkg::RST_EVT_ENABLE0;
      wc_cfg_q  <= tfm_pkg::RST_WETTING;
      mode_q    <= tfm_pkg::RST_INPUT_MODE;
    end
    else
    begin
      if (wr_main)
      begin
        blk_src_q <= hwdata[tfm_pkg::MS_BLK_SRC];
        blk_snk_q <= hwdata[tfm_pkg::MS_BLK_SNK];
      end
      if (wr_en0)
        en0_q <= hwdata & (32'h1 << tfm_pkg::EN_CHK_IRQ);
      if (wr_wc)
        wc_cfg_q <= hwdata[3*NCH-1:0];
      if (wr_mode)
        mode_q <= hwdata[NCH-1:0];
    end
  end

  // ****************************************
  // checksum control
  // ****************************************
  tfm_crc_if #(.IW(7)) crc_bus ();
  // config words in ascending address order, reserved bits as zero
  wire [127:0] cfg_vec = {29'h0, blk_snk_q, blk_src_q, go_q, en0_q, 32'(wc_cfg_q), 32'(mode_q)}; // R20
  assign crc_bus.start  = go_start; // R21
  assign crc_bus.bit_in = cfg_vec[7'd127 - crc_bus.bit_idx]; // R24
  tfm_crc #(.NBITS(tfm_pkg::CFG_BITS), .IW(7)) u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .crc     (crc_bus.eng)
  );
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      go_q  <= 1'b0;
      chk_q <= 16'h0000;
    end
    else
    begin
      if (crc_bus.done)
      begin
        go_q  <= 1'b0; // R22
        chk_q <= crc_bus.result; // R21
      end
      else if (go_start)
        go_q <= 1'b1; // R22
    end
  end

  // ****************************************
  // thermal state machine
  // ****************************************
  logic warn_evt;
  logic sd_evt;
  logic first_poll_q;
  logic poll_rst_q;
  // events only on state changes, so a standing condition stays quiet
  always_comb
  begin
    warn_evt = 1'b0;
    sd_evt   = 1'b0;
    unique case (st_q)
      TFM_NORMAL:   warn_evt = w_above; // R1 R6
      TFM_WARN:
      begin
        sd_evt   = s_above; // R10
        warn_evt = ~s_above & ~w_hold; // R8
      end
      TFM_SHUTDOWN: sd_evt = ~s_hold; // R13
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q         <= TFM_NORMAL;
      first_poll_q <= 1'b0;
      poll_rst_q   <= 1'b0;
    end
    else
    begin
      poll_rst_q <= 1'b0;
      unique case (st_q)
        TFM_NORMAL:
          if (w_above)
            st_q <= TFM_WARN; // R2
        TFM_WARN:
          if (s_above)
            st_q <= TFM_SHUTDOWN; // R10
          else if (!w_hold)
            st_q <= TFM_NORMAL; // R4 R8
        TFM_SHUTDOWN:
          if (!s_hold)
          begin
            st_q       <= TFM_WARN; // R12 R13 R14
            poll_rst_q <= 1'b1; // R15
          end
      endcase
      if (sd_evt && st_q == TFM_SHUTDOWN)
        first_poll_q <= 1'b1; // R15
      else if (poll_cycle_done)
        first_poll_q <= 1'b0;
    end
  end

  // ****************************************
  // wetting current derating
  // ****************************************
  logic [3*NCH-1:0] wc_d;
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      // upper half of the channels face the sources, lower the sinks
      wire [2:0] code  = wc_cfg_q[3*g +: 3];
      wire       blk   = (g >= NCH/2) ? blk_src_q : blk_snk_q; // R7
      wire       high  = (code == tfm_pkg::WC_10MA) | (code == tfm_pkg::WC_15MA);
      assign wc_d[3*g +: 3] = (warn_live & ~blk & high) ? tfm_pkg::WC_2MA : code; // R3 R4 R14
    end
  endgenerate

  // ****************************************
  // serial frame engine
  // ****************************************
  logic [31:0] rx_q;
  logic [5:0]  cnt_q;
  logic [31:0] tx_q;
  logic [23:0] resp_q;
  logic        so_q;
  logic        so_oe_q;
  wire frame_full = (cnt_q == 6'(tfm_pkg::FRAME_W));
  wire par_ok     = ^rx_q; // R17
  wire rx_valid   = cs_rise & frame_full & par_ok;
  wire par_bad    = cs_rise & frame_full & ~par_ok; // R17
  wire evt_read   = rx_valid & ~rx_q[31] & (rx_q[30:25] == 6'(tfm_pkg::OFF_EVT_STATUS[4:2])); // R5
  wire therm_flag = evt_q[tfm_pkg::EV_WARN] | evt_q[tfm_pkg::EV_SHUTDOWN] | warn_live; // R1 R10
  wire [30:0] tx_body = {therm_flag, evt_q[tfm_pkg::EV_PARITY], evt_q[tfm_pkg::EV_SWITCH], // R18
                         evt_q[tfm_pkg::EV_CHK_DONE], 3'h0, resp_q};
  wire [31:0] tx_load = {tx_body, ~^tx_body}; // R16
  // runs on in shutdown; only registers here, nothing is reset there
  always_ff @(posedge hclk or negedge hresetn) // R11
  begin
    if (!hresetn)
    begin
      rx_q    <= 32'h0000_0000;
      cnt_q   <= 6'h00;
      tx_q    <= 32'h0000_0000;
      resp_q  <= 24'h00_0000;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else
    begin
      so_oe_q <= ~cs_s;
      if (cs_fall)
      begin
        cnt_q <= 6'h00;
        tx_q  <= tx_load;
        so_q  <= tx_load[31];
      end
      else if (sck_dn)
      begin
        tx_q <= {tx_q[30:0], 1'b0};
        so_q <= tx_q[30];
      end
      if (sck_up && !frame_full)
      begin
        rx_q  <= {rx_q[30:0], si_s};
        cnt_q <= cnt_q + 6'h01;
      end
      if (rx_valid && !rx_q[31])
        resp_q <= 24'(reg_read(rx_q[27:25]));
    end
  end

  // ****************************************
  // event register and alert pin
  // ****************************************
  logic [NUM_EVT-1:0] evt_set;
  logic               alert_q;
  logic               poll_first_done;
  assign poll_first_done = first_poll_q & poll_cycle_done; // R15
  assign evt_set = {crc_bus.done, par_bad, sd_evt, warn_evt, poll_first_done}; // R1 R8 R10 R13 R17 R21
  wire irq_new = |(evt_set & {en0_q[tfm_pkg::EN_CHK_IRQ], 4'hF}); // R23 R7
  // a new event in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evt_q   <= '0;
      alert_q <= 1'b0;
    end
    else
    begin
      evt_q   <= (evt_read ? '0 : evt_q) | evt_set; // R5
      alert_q <= (alert_q & ~evt_read) | irq_new; // R5
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [3*NCH-1:0] wc_q;
  logic             wc_on_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wc_q    <= '0;
      wc_on_q <= 1'b1;
    end
    else
    begin
      wc_q    <= wc_d;
      wc_on_q <= ~sd_live & ~(sd_evt & ~sd_live); // R9
    end
  end
  assign hreadyout    = hready_q;
  assign hrdata       = hrdata_q;
  assign hresp        = 1'b0;
  assign so           = so_q;
  assign so_oe        = so_oe_q;
  assign alert_n      = ~alert_q;
  assign poll_restart = poll_rst_q;
  assign wc_level     = wc_q;
  assign wc_switch_on = wc_on_q;
  assign input_mode   = mode_q;
endmodule

// ===== bench/tfm_top_sva.sv
// checker on the monitor's alert, thermal and serial pins
// assumes it is bound into tfm_top and sees its ports only
module tfm_top_sva #(
  parameter int NCH = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // serial link and alert
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic alert_n,
  // temperature and polling
  input wire logic warn_above,
  input wire logic warn_hold,
  input wire logic sd_above,
  input wire logic sd_hold,
  input wire logic poll_restart,
  input wire logic wc_switch_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************
  // frame tracking
  // ******************
  logic [2:0] sck_q;
  logic [1:0] cs_q;
  logic [5:0] cnt_q;
  logic       par_q;
  wire        sck_rise = sck_q[1] & ~sck_q[2];
  // so is taken three clocks after the sclk rise, well before it moves
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_q <= 3'h0;
      cs_q  <= 2'h3;
      cnt_q <= 6'h00;
      par_q <= 1'b0;
    end
    else
    begin
      sck_q <= {sck_q[1:0], sclk};
      cs_q  <= {cs_q[0], cs_n};
      if (cs_q[1])
      begin
        cnt_q <= 6'h00;
        par_q <= 1'b0;
      end
      else if (sck_rise)
      begin
        cnt_q <= cnt_q + 6'h01;
        par_q <= par_q ^ so;
      end
    end
  end
  // ******************
  // properties
  // ******************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_warm_rise;
    $rose(warn_above) && !$past(warn_hold);
  endsequence
  sequence s_frame_end;
    cs_q[0] && !cs_q[1] && cnt_q == 6'h20;
  endsequence
  a_warn_alert: assert property (s_warm_rise |-> ##[1:6] !alert_n)
    else $error("alert stayed high after a warning");
  a_cool_alert: assert property ($fell(warn_hold) && !sd_hold |-> ##[1:6] !alert_n)
    else $error("alert stayed high after cooling");
  a_sd_opens: assert property ((sd_above && warn_above)[*8] |-> !wc_switch_on)
    else $error("switches closed while above shutdown");
  a_sd_alert: assert property ($fell(wc_switch_on) |-> ##[0:3] !alert_n)
    else $error("no alert on entering shutdown");
  a_sd_held: assert property ($rose(wc_switch_on) |-> !$past(sd_hold, 2))
    else $error("shutdown left within hysteresis");
  a_restart_sd: assert property (poll_restart |-> ##[0:2] wc_switch_on)
    else $error("poll restart without leaving shutdown");
  a_restart_one: assert property (poll_restart |=> !poll_restart)
    else $error("poll restart longer than one cycle");
  a_alert_release: assert property ($rose(alert_n) |-> cs_n)
    else $error("alert released while selected");
  a_odd_parity: assert property (s_frame_end |-> par_q)
    else $error("outgoing frame has even parity");
  a_link_drive: assert property ($stable(cs_n)[*4] |-> so_oe != cs_n)
    else $error("so enable does not follow select");
endmodule

bind tfm_top tfm_top_sva #(.NCH(NCH)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .sclk(sclk), .cs_n(cs_n), .so(so), .so_oe(so_oe),
  .alert_n(alert_n), .warn_above(warn_above), .warn_hold(warn_hold), .sd_above(sd_above),
  .sd_hold(sd_hold), .poll_restart(poll_restart), .wc_switch_on(wc_switch_on)
);

// ===== bench/tfm_host.sv
// serial host model: msb first, si moves on sclk fall, so read at rise
// assumes hclk at 40 MHz; sclk 200 ns and still low between frames
module tfm_host (
  // bench clock
  input  wire logic hclk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end
  // one whole frame; bad turns the parity round on purpose
  task automatic xfer(input logic [30:0] cmd, logic bad, output logic [31:0] rx);
    logic [31:0] tx;
    tx = {cmd, ~^cmd ^ bad};
    @(posedge hclk);
    cs_n <= 1'b0;
    si   <= tx[31];
    repeat (8) @(posedge hclk);
    for (int i = 31; i >= 0; i--)
    begin
      rx[i] = so;
      sclk <= 1'b1;
      repeat (4) @(posedge hclk);
      sclk <= 1'b0;
      si   <= (i > 0) ? tx[i-1] : ~tx[0];
      repeat (4) @(posedge hclk);
    end
    // deselect only after the read, so a read of events clears them
    cs_n <= 1'b1;
    repeat (12) @(posedge hclk);
  endtask
endmodule

// ===== bench/tfm_top_test.sv
// self-checking bench for the thermal fault and integrity monitor
// assumes the host model and the bound checker are compiled with it
module tfm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 8;
  localparam logic [4:0] MS = tfm_pkg::OFF_MAIN_SETUP;
  localparam logic [4:0] EN = tfm_pkg::OFF_EVT_ENABLE0;
  localparam logic [4:0] MI = tfm_pkg::OFF_MISC_STATUS;
  localparam logic [4:0] EV = tfm_pkg::OFF_EVT_STATUS;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]      haddr, hwdata, hrdata, rx;
  logic [1:0]       htrans;
  logic             sclk, cs_n, si, so, so_oe, alert_n, poll_restart, wc_switch_on;
  logic             warn_above, warn_hold, sd_above, sd_hold, poll_cycle_done;
  logic [3*NCH-1:0] wc_level, wc_s;
  logic [NCH-1:0]   input_mode;
  logic             rdy_s, al_s, sw_s, rd_pend;
  logic [31:0]      exp_q[$];
  logic [23:0]      wcfg;
  logic [7:0]       imode;
  int               n_errors, n_checks, n_rst;

  tfm_top #(.NCH(NCH)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .alert_n(alert_n),
    .warn_above(warn_above), .warn_hold(warn_hold), .sd_above(sd_above), .sd_hold(sd_hold),
    .poll_cycle_done(poll_cycle_done), .poll_restart(poll_restart), .wc_level(wc_level),
    .wc_switch_on(wc_switch_on), .input_mode(input_mode)
  );
  tfm_host host_u (.hclk(hclk), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so_oe ? so : ~so));

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // ******************
  // checking
  // ******************
  task automatic chk(input logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic v, logic e);
    chk({31'h0, v}, {31'h0, e});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // outputs copied mid-cycle so a driver never races a flop update
  always @(negedge hclk)
  begin
    rdy_s = hreadyout;
    al_s  = alert_n;
    sw_s  = wc_switch_on;
    wc_s  = wc_level;
    if (poll_restart === 1'b1)
      n_rst++;
    if (rd_pend && hreadyout === 1'b1)
    begin
      rd_pend = 1'b0;
      chk(hrdata, exp_q.pop_front());
    end
  end
  // ******************
  // drivers
  // ******************
  task automatic bus(input logic w, logic [4:0] a, logic [31:0] d, logic [31:0] e);
    hsel   <= 1'b1;
    haddr  <= {27'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
    begin
      exp_q.push_back(e);
      rd_pend = 1'b1;
    end
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
  endtask
  task automatic rd(input logic [4:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0, e);
  endtask
  task automatic wr(input logic [4:0] a, logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask
  task automatic ser(input logic [5:0] idx, input logic bad);
    host_u.xfer({1'b0, idx, 24'h000000}, bad, rx);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // expected drive: 10 and 15 mA fall to 2 mA unless that side is blocked
  function automatic logic [23:0] derate(logic [23:0] c, logic src, logic snk);
    logic [23:0] r;
    r = c;
    for (int n = 0; n < NCH; n++)
      if ((c[3*n+:3] == tfm_pkg::WC_10MA || c[3*n+:3] == tfm_pkg::WC_15MA) && !(n >= NCH/2 ? src : snk))
        r[3*n+:3] = tfm_pkg::WC_2MA;
    return r;
  endfunction
  function automatic logic [15:0] crc16(logic [127:0] m);
    logic [15:0] c;
    c = tfm_pkg::CRC_SEED;
    for (int i = 127; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? tfm_pkg::CRC_POLY : 16'h0000);
    return c ^ tfm_pkg::CRC_XOR;
  endfunction
  // ******************
  // tests
  // ******************
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, rd_pend} = '0;
    {warn_above, warn_hold, sd_above, sd_hold, poll_cycle_done} = '0;
    void'($urandom(61));
    cyc(20);
    hresetn <= 1'b1;
    cyc(1);
    rd(EN, tfm_pkg::RST_EVT_ENABLE0);
    rd(tfm_pkg::OFF_WETTING, {8'h00, tfm_pkg::RST_WETTING});
    rd(MI, 32'h0);
    wr(5'h1C, 32'hFFFFFFFF);
    rd(5'h1C, 32'h0);
    $display("test reset done");
    // reserved bits are written dirty; the checksum must see zeros
    for (int n = 0; n < NCH; n++)
      wcfg[3*n+:3] = 3'($urandom_range(5));
    wcfg[2:0] = tfm_pkg::WC_10MA;
    wcfg[23:21] = tfm_pkg::WC_15MA;
    imode = 8'($urandom);
    wr(tfm_pkg::OFF_WETTING, {8'hA5, wcfg});
    wr(tfm_pkg::OFF_INPUT_MODE, {24'h5A0000, imode});
    for (int k = 0; k < 2; k++)
    begin
      wr(MS, 32'h1);
      rd(MS, 32'h1);
      cyc(150);
      rd(MS, 32'h0);
      rd(tfm_pkg::OFF_CHECKSUM, 32'(crc16({32'h1, k ? 32'h0 : 32'h10, 8'h0, wcfg, 24'h0, imode})));
      rd(EV, 32'h10);
      pin(al_s, k[0]);
      if (k == 0)
        ser(6'h06, 1'b0);
      wr(EN, 32'h0);
    end
    chk({24'h0, input_mode}, {24'h0, imode});
    ser(6'h06, 1'b1);
    pin(al_s, 1'b0);
    rd(EV, 32'h18);
    ser(6'h06, 1'b0);
    pin(rx[30], 1'b1);
    cyc(4);
    pin(al_s, 1'b1);
    rd(EV, 32'h0);
    $display("test checksum and parity done");
    for (int b = 0; b < 2; b++)
    begin
      wr(MS, {29'h0, b[0], ~b[0], 1'b0});
      warn_above <= 1'b1;
      warn_hold <= 1'b1;
      cyc(10);
      pin(al_s, 1'b0);
      chk({8'h0, wc_s}, {8'h0, derate(wcfg, ~b[0], b[0])});
      rd(MI, 32'h1);
      rd(EV, 32'h2);
      ser(6'h05, 1'b0);
      pin(al_s, 1'b0);
      ser(6'h06, 1'b0);
      pin(rx[31], 1'b1);
      warn_above <= 1'b0;
      cyc(10);
      pin(al_s, 1'b1);
      chk({8'h0, wc_s}, {8'h0, derate(wcfg, ~b[0], b[0])});
      rd(MI, 32'h1);
      warn_hold <= 1'b0;
      cyc(10);
      pin(al_s, 1'b0);
      chk({8'h0, wc_s}, {8'h0, wcfg});
      rd(MI, 32'h0);
      rd(EV, 32'h2);
      ser(6'h06, 1'b0);
    end
    $display("test warning done");
    wr(MS, 32'h0);
    warn_above <= 1'b1;
    warn_hold <= 1'b1;
    cyc(10);
    ser(6'h06, 1'b0);
    sd_above <= 1'b1;
    sd_hold <= 1'b1;
    cyc(10);
    pin(sw_s, 1'b0);
    pin(al_s, 1'b0);
    rd(MI, 32'h3);
    rd(EV, 32'h4);
    ser(6'h03, 1'b0);
    ser(6'h06, 1'b0);
    chk({8'h0, rx[24:1]}, {24'h0, imode});
    sd_above <= 1'b0;
    cyc(10);
    pin(sw_s, 1'b0);
    pin(al_s, 1'b1);
    rd(MI, 32'h3);
    sd_hold <= 1'b0;
    cyc(10);
    pin(sw_s, 1'b1);
    pin(al_s, 1'b0);
    rd(MI, 32'h1);
    rd(EV, 32'h4);
    chk({8'h0, wc_s}, {8'h0, derate(wcfg, 1'b0, 1'b0)});
    poll_cycle_done <= 1'b1;
    cyc(1);
    poll_cycle_done <= 1'b0;
    cyc(4);
    rd(EV, 32'h5);
    chk(32'(n_rst), 32'h1);
    ser(6'h06, 1'b0);
    warn_above <= 1'b0;
    warn_hold <= 1'b0;
    cyc(10);
    $display("test shutdown done");
    results();
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial
  begin
    cyc(30000);
    n_errors++;
    results();
  end
endmodule
